// [cmsc_top.sv]
// cmsc_top: chip mode latch, power state sequencer and flash security gating.
// assumes: ref_clk is always-on; event inputs are one-cycle pulses from ref_clk logic;
// the option byte input is stable from reset until the capture cycle.
//
// Overview of operation
// - mode pin high selects normal single-chip, low selects special single-chip.
// - mode pin level is latched into the mode bit as reset releases.
// - mode bit shows the current mode; only special to normal switch allowed.
// - normal mode boots from on-chip reset vector, internal memory only.
// - special mode enters background debug state directly on leaving reset.
// - freezable modules hold status when debug state active and freeze programmed.
// - wait instruction enters wait; processor clock gated, peripherals may run.
// - reset, nonmaskable, external or unmasked interrupt ends wait mode.
// - pseudo-stop halts system clocks, oscillator runs, five timers may stay.
// - stop halts oscillator and clocks, freezes counters; six wake sources.
// - debug enabled in stop with clock include set keeps all clocks.
// - debug enabled in stop with clock include clear keeps only serial clock.
// - debug enabled in stop keeps regulator, power unit and voltage monitor.
// - option byte copied into security register each reset; two-bit field used.
// - unsecured only for field value 10; every other value is secured.
// - secured normal mode disables debug controller and restricts flash commands.
// - secured special mode allows only mass erase and control/status commands.
// - backdoor unsecure only in normal mode with key enabled and valid key.
// - key words of all zeros or all ones are invalid.
// - option byte erase/program blocked while its sector is protected.
// - reprogrammed unsecure code takes effect only after the next reset.
// - successful full erase unsecures and programs the unsecured code.
`timescale 1ns/1ns
module cmsc_top
    import cmsc_pkg::*;
#(
    parameter int NKEY = KEY_WORDS
) (
    input wire logic ref_clk, // 25 MHz system clock
    input wire logic rstn, // async reset, active low
    input wire logic mode_select_pin, // raw mode pin level
    input wire logic [OPT_W-1:0] option_byte, // flash option and security byte
    input wire logic mode_write, // software mode write strobe
    input wire logic mode_write_value, // requested mode bit
    input wire logic bdm_enter, // debug controller asks for debug state
    input wire logic bdm_exit, // debug controller leaves debug state
    input wire logic freeze_option, // freeze option programmed
    input wire logic wait_instruction, // processor executed wait
    input wire logic stop_instruction, // processor executed stop
    input wire logic pseudo_stop_sel, // stop request means pseudo-stop
    input wire logic nonmaskable_irq, // non-maskable interrupt
    input wire logic ext_irq, // external interrupt
    input wire logic unmasked_irq, // any other unmasked interrupt
    input wire logic periodic_interrupt, // periodic interrupt wake
    input wire logic watchdog_timer, // watchdog wake
    input wire logic autonomous_wakeup_timer, // autonomous timer wake
    input wire logic key_wakeup, // key wakeup
    input wire logic rtc_wakeup, // real-time clock wake
    input wire logic can_wakeup, // CAN wake
    input wire logic background_debug_controller, // debug controller enabled
    input wire logic debug_clock_include, // keep all clocks in stop
    input wire logic dbg_cmd_valid, // debug command presented
    input wire logic dbg_cmd_mass_erase, // command is mass erase
    input wire logic dbg_cmd_csr, // command is control/status access
    input wire logic [NKEY*KEY_WORD_W-1:0] stored_key, // programmed backdoor key
    input wire logic [NKEY*KEY_WORD_W-1:0] entered_key, // key written by software
    input wire logic key_submit, // backdoor key compare strobe
    input wire logic opt_write_req, // erase/program of option byte
    input wire logic opt_sector_protected, // option byte sector protected
    input wire logic full_erase_done, // full flash erase completed ok
    output logic mode_bit, // current mode, 1 normal
    output logic startup_done, // mode and security captured
    output logic boot_internal, // fetch reset vector from on-chip memory
    output logic cpu_run_enable, // processor may execute
    output logic background_debug_state, // debug state active
    output logic freeze_active, // freezable modules hold status
    output cmsc_pwr_type pwr_state, // current power state
    output logic cpu_clk_en, // processor clock enable
    output logic bus_clk_en, // bus clock enable
    output logic debug_serial_clock, // debug serial clock enable
    output logic osc_en, // oscillator enable
    output logic counter_freeze, // freeze counters and dividers
    output logic periph_run_en, // general peripherals enabled
    output logic [LP_W-1:0] lp_periph_en, // timers allowed in pseudo-stop
    output logic voltage_regulator_full, // regulator in full performance
    output logic clock_power_unit_run, // power unit operates as in run
    output logic voltage_monitor_en, // voltage monitoring active
    output logic [1:0] security_field, // field held in security register
    output logic secured, // device secured
    output logic debug_enable, // debug controller allowed
    output logic dbg_mem_access_en, // debug memory mapped access allowed
    output logic dbg_cmd_accept, // current debug command accepted
    output logic flash_cmd_restricted, // flash/eeprom commands restricted
    output logic backdoor_unsecured, // temporarily unsecured by key
    output logic opt_write_grant, // option byte write allowed
    output logic sec_program_req, // request to program unsecured code
    output logic [1:0] sec_program_value // value to program
);
    logic mode_pin_sync;
    logic [1:0] startup_cnt;
    logic [OPT_W-1:0] flash_security_reg;
    logic erase_unsecured;
    logic key_words_ok;
    logic [NKEY-1:0] word_ok;
    logic key_allowed;
    logic capture;
    logic wake_wait;
    logic wake_stop;
    logic wake_pstop;
    logic in_static;
    logic dbg_in_static;
    cmsc_pwr_type next_pwr_state;

    cmsc_sync2 #(.W(1)) u_mode_sync (
        .clk(ref_clk),
        .rstn(rstn),
        .async_in(mode_select_pin),
        .sync_out(mode_pin_sync)
    );

    // wait for the synchroniser to settle before taking the pin level
    assign capture = !startup_done && (startup_cnt == CAPTURE_CYCLE);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            startup_cnt <= '0;
            startup_done <= 1'b0;
        end else if (!startup_done) begin
            startup_cnt <= startup_cnt + 2'h1;
            startup_done <= capture;
        end
    end

    // mode bit: pin level at release, then only special to normal
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_bit <= MODE_SPECIAL;
        end else if (capture) begin
            mode_bit <= mode_pin_sync;
        end else if (startup_done && mode_write && mode_bit == MODE_SPECIAL) begin
            mode_bit <= mode_write_value;
        end
    end

    // security register loads once per reset and holds until the next
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flash_security_reg <= {{(OPT_W-2){1'b1}}, SEC_RESET};
        end else if (capture) begin
            flash_security_reg <= option_byte;
        end
    end

    assign security_field = flash_security_reg[SEC_LO +: 2];

    generate
        for (genvar i = 0; i < NKEY; i++) begin : g_key
            assign word_ok[i] = stored_key[i*KEY_WORD_W +: KEY_WORD_W] != KEY_ALL_ZERO
                && stored_key[i*KEY_WORD_W +: KEY_WORD_W] != KEY_ALL_ONE;
        end
    endgenerate
    assign key_words_ok = &word_ok;

    assign key_allowed = startup_done && mode_bit == MODE_NORMAL && key_words_ok
        && flash_security_reg[KEYEN_LO +: 2] == KEYEN_ENABLED;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            backdoor_unsecured <= 1'b0;
        end else if (key_submit && key_allowed && entered_key == stored_key) begin
            backdoor_unsecured <= 1'b1;
        end
    end

    // full erase unsecures at once and writes the unsecured code back
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            erase_unsecured <= 1'b0;
            sec_program_req <= 1'b0;
            sec_program_value <= SEC_RESET;
        end else begin
            sec_program_req <= full_erase_done;
            if (full_erase_done) begin
                erase_unsecured <= 1'b1;
                sec_program_value <= SEC_UNSECURED;
            end
        end
    end

    // secured until startup; decoded from the held register, backdoor and erase flags
    assign secured = !(startup_done && security_field == SEC_UNSECURED)
        && !backdoor_unsecured && !erase_unsecured;
    assign debug_enable = !(secured && mode_bit == MODE_NORMAL);
    assign dbg_mem_access_en = debug_enable && !secured;
    assign dbg_cmd_accept = dbg_cmd_valid && debug_enable
        && (!secured || dbg_cmd_mass_erase || dbg_cmd_csr);
    assign flash_cmd_restricted = secured;
    assign opt_write_grant = opt_write_req && !opt_sector_protected;

    assign boot_internal = mode_bit == MODE_NORMAL;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            background_debug_state <= 1'b0;
        end else if (capture) begin
            background_debug_state <= mode_pin_sync == MODE_SPECIAL;
        end else if (bdm_enter && debug_enable) begin
            background_debug_state <= 1'b1;
        end else if (bdm_exit) begin
            background_debug_state <= 1'b0;
        end
    end

    assign freeze_active = background_debug_state && freeze_option;
    assign cpu_run_enable = startup_done && !background_debug_state;

    assign wake_wait = nonmaskable_irq || ext_irq || unmasked_irq;
    assign wake_stop = autonomous_wakeup_timer || key_wakeup || rtc_wakeup
        || can_wakeup;
    assign wake_pstop = wake_stop || periodic_interrupt || watchdog_timer;

    always_comb begin
        next_pwr_state = pwr_state;
        unique case (pwr_state)
            PWR_RUN: begin
                if (wait_instruction && cpu_run_enable) begin
                    next_pwr_state = PWR_WAIT;
                end else if (stop_instruction && cpu_run_enable) begin
                    next_pwr_state = pseudo_stop_sel ? PWR_PSTOP : PWR_STOP;
                end
            end
            PWR_WAIT: begin
                if (wake_wait) begin
                    next_pwr_state = PWR_RUN;
                end
            end
            PWR_PSTOP: begin
                if (wake_pstop || nonmaskable_irq || ext_irq) begin
                    next_pwr_state = PWR_RUN;
                end
            end
            PWR_STOP: begin
                if (wake_stop || nonmaskable_irq || ext_irq) begin
                    next_pwr_state = PWR_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pwr_state <= PWR_RUN;
        end else begin
            pwr_state <= next_pwr_state;
        end
    end

    assign in_static = next_pwr_state == PWR_PSTOP || next_pwr_state == PWR_STOP;
    // a secured normal-mode device has no debug controller to keep alive
    assign dbg_in_static = in_static && background_debug_controller && debug_enable;

    // gating registered from the next state so enables track the state
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cpu_clk_en <= 1'b1;
            bus_clk_en <= 1'b1;
            debug_serial_clock <= 1'b1;
            osc_en <= 1'b1;
            counter_freeze <= 1'b0;
            periph_run_en <= 1'b1;
            lp_periph_en <= '1;
            voltage_regulator_full <= 1'b1;
            clock_power_unit_run <= 1'b1;
            voltage_monitor_en <= 1'b1;
        end else begin
            cpu_clk_en <= next_pwr_state == PWR_RUN
                || (dbg_in_static && debug_clock_include);
            bus_clk_en <= !in_static || (dbg_in_static && debug_clock_include);
            debug_serial_clock <= !in_static || dbg_in_static;
            osc_en <= next_pwr_state != PWR_STOP || dbg_in_static;
            counter_freeze <= next_pwr_state == PWR_STOP
                && !(dbg_in_static && debug_clock_include);
            periph_run_en <= !in_static || (dbg_in_static && debug_clock_include);
            lp_periph_en <= next_pwr_state == PWR_STOP ? LP_W'(1 << LP_AWT) | LP_W'(1 << LP_RTC)
                : '1;
            voltage_regulator_full <= !in_static || dbg_in_static;
            clock_power_unit_run <= !in_static || dbg_in_static;
            voltage_monitor_en <= next_pwr_state != PWR_STOP || dbg_in_static;
        end
    end

    // checks
    mode_latch_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        capture |=> mode_bit == $past(mode_pin_sync))
        else $error("mode bit not latched from pin");
    mode_lock_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        startup_done && mode_bit == MODE_NORMAL |=> mode_bit == MODE_NORMAL)
        else $error("mode left normal while running");
    special_bdm_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        capture && mode_pin_sync == MODE_SPECIAL |=> background_debug_state)
        else $error("special mode did not enter debug state");
    wait_clk_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        pwr_state == PWR_RUN && next_pwr_state == PWR_WAIT |=> !cpu_clk_en && bus_clk_en)
        else $error("wait mode clock gating wrong");
    wait_exit_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        pwr_state == PWR_WAIT && wake_wait |=> pwr_state == PWR_RUN)
        else $error("wait mode not left on interrupt");
    stop_freeze_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        pwr_state == PWR_STOP && !background_debug_controller |-> !osc_en && counter_freeze)
        else $error("stop did not halt oscillator");
    dbg_clocks_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        next_pwr_state == PWR_STOP && background_debug_controller && !debug_clock_include
        |=> debug_serial_clock && !bus_clk_en && voltage_regulator_full)
        else $error("debug stop clocks wrong");
    sec_decode_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        startup_done && !backdoor_unsecured && !erase_unsecured
        |-> secured == (security_field != SEC_UNSECURED))
        else $error("security decode wrong");
    sec_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        startup_done |=> $stable(security_field))
        else $error("security field changed before reset");
    ns_debug_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        secured && mode_bit == MODE_NORMAL |-> !dbg_cmd_accept && !debug_enable)
        else $error("debug not disabled when secured");
    ss_cmds_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        secured && dbg_cmd_accept |-> (dbg_cmd_mass_erase || dbg_cmd_csr) && !dbg_mem_access_en)
        else $error("secured debug command not filtered");
    erase_unsec_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        full_erase_done |=> !secured && sec_program_req && sec_program_value == SEC_UNSECURED)
        else $error("full erase did not unsecure");
    key_guard_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(backdoor_unsecured) |-> $past(key_allowed) && $past(key_words_ok))
        else $error("backdoor unsecured without valid key");
    opt_block_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        opt_sector_protected |-> !opt_write_grant)
        else $error("option write granted while protected");

    stop_cycle_c: cover property (@(posedge ref_clk) disable iff (!rstn)
        pwr_state == PWR_STOP ##[1:20] pwr_state == PWR_RUN);
    backdoor_c: cover property (@(posedge ref_clk) disable iff (!rstn)
        $rose(backdoor_unsecured));
    dbg_stop_c: cover property (@(posedge ref_clk) disable iff (!rstn)
        pwr_state == PWR_STOP && background_debug_controller && debug_clock_include);
endmodule : cmsc_top

// [cmsc_pkg.sv]
// cmsc_pkg: constants and types for the chip mode and security controller.
// assumes: imported whole by cmsc_top and the bench.
package cmsc_pkg;
    // chip modes as seen on the mode select pin and the mode bit
    localparam logic MODE_NORMAL = 1'b1;
    localparam logic MODE_SPECIAL = 1'b0;
    // security field codes
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam logic [1:0] SEC_RESET = 2'h3;
    // field positions inside the option and security byte
    localparam int SEC_LO = 0;
    localparam int KEYEN_LO = 6;
    localparam int OPT_W = 8;
    // backdoor key enable code that selects enabled (arbitrary choice)
    localparam logic [1:0] KEYEN_ENABLED = 2'h2;
    // backdoor key geometry and forbidden word values
    localparam int KEY_WORDS = 4;
    localparam int KEY_WORD_W = 16;
    localparam logic [15:0] KEY_ALL_ZERO = 16'h0000;
    localparam logic [15:0] KEY_ALL_ONE = 16'hffff;
    // cycles after reset release before the pin and option byte are taken
    localparam logic [1:0] CAPTURE_CYCLE = 2'h2;
    // low power peripheral enable mask bit positions
    localparam int LP_PERIODIC = 0;
    localparam int LP_WATCHDOG = 1;
    localparam int LP_RTC = 2;
    localparam int LP_LCD = 3;
    localparam int LP_AWT = 4;
    localparam int LP_W = 5;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_WAIT,
        PWR_PSTOP,
        PWR_STOP
    } cmsc_pwr_type;
endpackage : cmsc_pkg

// [cmsc_sync2.sv]
// cmsc_sync2: two flip-flop synchroniser for asynchronous levels.
// assumes: clk is the consuming domain; output is only valid two edges after input.
`timescale 1ns/1ns
module cmsc_sync2 #(
    parameter int W = 1
) (
    input wire logic clk, // consuming clock
    input wire logic rstn, // async reset, active low
    input wire logic [W-1:0] async_in, // level from outside the domain
    output logic [W-1:0] sync_out // synchronised level
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : cmsc_sync2

// [cmsc_dbg_host.sv]
// cmsc_dbg_host: behavioural external debug host facing the security gate.
// assumes: commands are levels sampled on ref_clk; bench selects kind and go.
`timescale 1ns/1ns
module cmsc_dbg_host (
    input wire logic ref_clk, // system clock
    input wire logic [1:0] req_kind, // 0 memory, 1 mass erase, 2 control/status
    input wire logic req_go, // present a command
    output logic dbg_cmd_valid, // command presented
    output logic dbg_cmd_mass_erase, // command is mass erase
    output logic dbg_cmd_csr, // command is control/status access
    output logic [1:0] secure_code, // code the host programs to secure
    output logic [63:0] host_key // backdoor key the host programs
);
    assign secure_code = 2'h1;
    // no word is all zeros or all ones
    assign host_key = 64'h1234_5678_9abc_4321;
    initial begin
        dbg_cmd_valid = 1'b0;
        dbg_cmd_mass_erase = 1'b0;
        dbg_cmd_csr = 1'b0;
    end
    always @(posedge ref_clk) begin
        #1;
        dbg_cmd_valid <= req_go;
        if (req_go) begin
            dbg_cmd_mass_erase <= (req_kind == 2'h1);
            dbg_cmd_csr <= (req_kind == 2'h2);
        end else begin
            // released kind lines toggle so stale values never look valid
            dbg_cmd_mass_erase <= ~dbg_cmd_mass_erase;
            dbg_cmd_csr <= ~dbg_cmd_csr;
        end
    end
endmodule : cmsc_dbg_host

// [test_chip_mode_security_ctrl.sv]
// test_chip_mode_security_ctrl: self-checking bench for cmsc_top.
// assumes: cmsc_dbg_host plays the debug host; inputs change 2 ns after the edge.
`timescale 1ns/1ns
module test_chip_mode_security_ctrl import cmsc_pkg::*; ();
    logic ref_clk = 0, rstn = 0, pin = 1, mw = 0, mwv = 0, be = 0, bx = 0, fo = 0;
    logic wi = 0, si = 0, ps = 0, bdc = 0, dci = 0, ks = 0, owr = 0, osp = 0, fed = 0, go = 0;
    logic [7:0] opt = 8'hff;
    logic [8:0] wk = 9'h000;
    logic [63:0] ek = 64'h0, sk = 64'h0, hk;
    logic [1:0] kind = 2'h0, sc, security_field, sec_program_value;
    logic dbg_cmd_valid, dbg_cmd_mass_erase, dbg_cmd_csr, mode_bit, startup_done;
    logic boot_internal, background_debug_state, freeze_active, cpu_clk_en, bus_clk_en;
    logic debug_serial_clock, osc_en, counter_freeze, voltage_regulator_full, secured;
    logic debug_enable, dbg_mem_access_en, dbg_cmd_accept, backdoor_unsecured;
    logic opt_write_grant, sec_program_req, cpu_run_enable, periph_run_en, flash_cmd_restricted;
    logic clock_power_unit_run, voltage_monitor_en;
    logic [4:0] lp_periph_en;
    cmsc_pwr_type pwr_state;
    int errors = 0, checks = 0;
    cmsc_dbg_host host (.ref_clk, .req_kind(kind), .req_go(go), .dbg_cmd_valid,
        .dbg_cmd_mass_erase, .dbg_cmd_csr, .secure_code(sc), .host_key(hk));
    cmsc_top uut (.ref_clk, .rstn, .mode_select_pin(pin), .option_byte(opt),
        .mode_write(mw), .mode_write_value(mwv), .bdm_enter(be), .bdm_exit(bx),
        .freeze_option(fo), .wait_instruction(wi), .stop_instruction(si),
        .pseudo_stop_sel(ps), .nonmaskable_irq(wk[0]), .ext_irq(wk[1]),
        .unmasked_irq(wk[2]), .periodic_interrupt(wk[3]), .watchdog_timer(wk[4]),
        .autonomous_wakeup_timer(wk[5]), .key_wakeup(wk[6]), .rtc_wakeup(wk[7]),
        .can_wakeup(wk[8]), .background_debug_controller(bdc), .debug_clock_include(dci),
        .dbg_cmd_valid, .dbg_cmd_mass_erase, .dbg_cmd_csr, .stored_key(sk),
        .entered_key(ek), .key_submit(ks), .opt_write_req(owr), .opt_sector_protected(osp),
        .full_erase_done(fed), .mode_bit, .startup_done, .boot_internal, .cpu_run_enable,
        .background_debug_state, .freeze_active, .pwr_state, .cpu_clk_en, .bus_clk_en,
        .debug_serial_clock, .osc_en, .counter_freeze, .periph_run_en, .lp_periph_en,
        .voltage_regulator_full, .clock_power_unit_run, .voltage_monitor_en,
        .security_field, .secured, .debug_enable, .dbg_mem_access_en, .dbg_cmd_accept,
        .flash_cmd_restricted, .backdoor_unsecured, .opt_write_grant, .sec_program_req,
        .sec_program_value);
    always #20 ref_clk = ~ref_clk;
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : cyc
    task automatic pulse(ref logic s);
        s = 1;
        cyc(1);
        s = 0;
    endtask : pulse
    task automatic rst(input logic p, input logic [1:0] k, input logic [1:0] s);
        rstn = 0;
        pin = p;
        opt = {k, 4'hf, s};
        cyc(20);
        rstn = 1;
        for (int i = 0; i < 10 && startup_done !== 1'b1; i++) cyc(1);
        chk(startup_done, 1, "startup");
    endtask : rst
    task automatic wake(input int i);
        wk[i] = 1;
        cyc(1);
        wk[i] = 0;
        cyc(1);
        chk(pwr_state, PWR_RUN, "wake");
    endtask : wake
    task t_mode;
        rst(1, KEYEN_ENABLED, SEC_UNSECURED);
        chk(mode_bit, 1, "normal mode");
        chk(boot_internal, 1, "boot internal");
        chk(cpu_run_enable, 1, "core runs");
        chk(background_debug_state, 0, "no debug");
        mwv = 0;
        pulse(mw);
        chk(mode_bit, 1, "mode kept");
        rst(0, KEYEN_ENABLED, SEC_UNSECURED);
        chk(mode_bit, 0, "special mode");
        chk(background_debug_state, 1, "debug on");
        chk(cpu_run_enable, 0, "core held");
        fo = 1;
        cyc(1);
        chk(freeze_active, 1, "freeze");
        pulse(bx);
        chk(freeze_active, 0, "unfreeze");
        pulse(be);
        chk(background_debug_state, 1, "debug again");
        fo = 0;
        mwv = 1;
        pulse(mw);
        chk(mode_bit, 1, "to normal");
        $display("test mode done");
    endtask : t_mode
    task t_sec;
        for (int c = 0; c < 4; c++) begin
            rst(1, KEYEN_ENABLED, 2'(c));
            chk(security_field, 8'(c), "field");
            chk(secured, c != 2, "decode");
            chk(debug_enable, c == 2, "debug gate");
            chk(flash_cmd_restricted, c != 2, "flash gate");
        end
        rst(0, KEYEN_ENABLED, sc);
        go = 1;
        for (int k = 0; k < 3; k++) begin
            kind = 2'(k);
            cyc(2);
            chk(dbg_cmd_accept, k != 0, "cmd filter");
        end
        chk(dbg_mem_access_en, 0, "mem blocked");
        go = 0;
        $display("test security done");
    endtask : t_sec
    task t_unsec;
        rst(1, KEYEN_ENABLED, sc);
        go = 1;
        cyc(2);
        chk(dbg_cmd_accept, 0, "debug off");
        go = 0;
        owr = 1;
        osp = 1;
        cyc(1);
        chk(opt_write_grant, 0, "protected");
        osp = 0;
        cyc(1);
        chk(opt_write_grant, 1, "granted");
        owr = 0;
        opt = {KEYEN_ENABLED, 4'hf, SEC_UNSECURED};
        sk = {hk[63:16], 16'h0000};
        ek = sk;
        pulse(ks);
        chk(secured, 1, "held to reset");
        chk(backdoor_unsecured, 0, "zero word");
        sk = hk;
        ek = ~hk;
        cyc(1);
        pulse(ks);
        chk(backdoor_unsecured, 0, "wrong key");
        ek = hk;
        cyc(1);
        pulse(ks);
        chk(secured, 0, "key unsecures");
        rst(1, KEYEN_ENABLED, SEC_UNSECURED);
        chk(secured, 0, "new code");
        rst(1, 2'h1, sc);
        pulse(ks);
        chk(backdoor_unsecured, 0, "key disabled");
        cyc(1);
        pulse(fed);
        chk(sec_program_req, 1, "erase program");
        chk(sec_program_value, SEC_UNSECURED, "erase code");
        chk(secured, 0, "erase unsecures");
        cyc(1);
        chk(sec_program_req, 0, "one pulse");
        $display("test unsecure done");
    endtask : t_unsec
    task t_power;
        rst(1, KEYEN_ENABLED, SEC_UNSECURED);
        for (int i = 0; i < 3; i++) begin
            pulse(wi);
            chk(pwr_state, PWR_WAIT, "wait");
            chk(cpu_clk_en, 0, "cpu gated");
            wake(i);
        end
        for (int i = 5; i < 9; i++) begin
            pulse(si);
            chk(osc_en, 0, "osc off");
            chk(counter_freeze, 1, "frozen");
            chk(voltage_monitor_en, 0, "monitor off");
            wk[3] = 1;
            cyc(2);
            wk[3] = 0;
            chk(pwr_state, PWR_STOP, "no wake");
            wake(i);
        end
        ps = 1;
        pulse(si);
        chk(pwr_state, PWR_PSTOP, "pseudo stop");
        chk(osc_en, 1, "osc runs");
        chk(bus_clk_en, 0, "bus off");
        chk(lp_periph_en, 8'h1f, "timers kept");
        chk(periph_run_en, 0, "periph off");
        wake(3);
        ps = 0;
        bdc = 1;
        dci = 1;
        pulse(si);
        chk(bus_clk_en, 1, "all clocks");
        chk(cpu_clk_en, 1, "core clock");
        chk(periph_run_en, 1, "periph on");
        wake(8);
        dci = 0;
        pulse(si);
        chk(bus_clk_en, 0, "bus gated");
        chk(debug_serial_clock, 1, "serial kept");
        chk(voltage_regulator_full, 1, "regulator");
        chk(clock_power_unit_run, 1, "power unit");
        chk(voltage_monitor_en, 1, "monitor on");
        wake(6);
        bdc = 0;
        $display("test power done");
    endtask : t_power
    task end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    initial begin
        #(40 * 20000);
        errors++;
        end_of_test;
    end
    initial begin
        t_mode;
        t_sec;
        t_unsec;
        t_power;
        end_of_test;
    end
endmodule : test_chip_mode_security_ctrl
